// ### hpsr_pkg.sv
// Package for the host port strobe, request and acknowledge pin block
// Functional notes
// [RULE_01] Strobe active and direction high: drive the eight data lines to the host.
// [RULE_02] Strobe active and direction low: data lines are inputs from the host; the code also drives them on acknowledge while service is pending.
// [RULE_03] Write data is captured on the deasserting (rising) edge of the strobe.
// [RULE_04] Open-drain service request asks the host or DMA for service.
// [RULE_05] Acknowledge input is the DMA handshake answering the service request.
// [RULE_06] Acknowledge input also accepts a host interrupt-acknowledge cycle.
// [RULE_07] Host port not selected: the three pins become port-B lines 12, 13, 14.
// [RULE_08] After reset the three port-B lines are general-purpose inputs.
// [RULE_09] Port-B line 13 drives push-pull, not open-drain.
// [RULE_10] Host should form the strobe from chip select and an enable strobe.
// [RULE_11] Host holds direction select stable while the strobe is asserted.
// [RULE_12] Host-port mode: data lines float whenever the strobe is deasserted; the code also drives them on acknowledge while service is pending.
// [RULE_13] Host drives the three register-select inputs for each access.
// [RULE_14] Request pulls low when service is pending, else released to float.
`default_nettype none
package hpsr_pkg;
  localparam int DATA_W = 8;
  localparam int SEL_W  = 3;
  localparam int GP_W   = 3;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [GP_W-1:0]   GP_RST   = 3'h0;
  localparam logic [SEL_W-1:0]  SEL_RST  = 3'h0;
  localparam int GP_STROBE = 0;
  localparam int GP_REQ    = 1;
  localparam int GP_ACK    = 2;

  // One captured host write
  typedef struct packed {
    logic [SEL_W-1:0]  sel;
    logic [DATA_W-1:0] data;
  } hpsr_write_t;

  // Port-B general-purpose control for lines 12..14
  typedef struct packed {
    logic [GP_W-1:0] dir;
    logic [GP_W-1:0] out;
  } hpsr_gpio_t;
endpackage
`default_nettype wire

// ### hpsr_host_pins.sv
// Host port strobe, service request and acknowledge pin logic
`timescale 1ns/100ps
`default_nettype none
module hpsr_host_pins (
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         reset,
  input  wire logic                         clkEn,
  // Mode and core side
  input  wire logic                         hostPortSel,
  input  wire logic [hpsr_pkg::DATA_W-1:0]  readData,
  input  wire logic                         servicePending,
  input  wire hpsr_pkg::hpsr_gpio_t         gpioCtl,
  output hpsr_pkg::hpsr_write_t             writeWord,
  output logic                              writeStrobe,
  output logic                              dmaAck,
  output logic                              intAck,
  output logic [hpsr_pkg::GP_W-1:0]         gpioIn,
  // Host pins
  input  wire logic                         hostTransferStrobeN,
  input  wire logic                         hostDirectionSelect,
  input  wire logic [hpsr_pkg::SEL_W-1:0]   hostRegisterSelect,
  input  wire logic [hpsr_pkg::DATA_W-1:0]  hostDataLinesIn,
  output logic [hpsr_pkg::DATA_W-1:0]       hostDataLinesOut,
  output logic                              hostDataLinesOe,
  input  wire logic                         hostServiceRequestIn,
  output logic                              hostServiceRequestOut,
  output logic                              hostServiceRequestOe,
  input  wire logic                         hostAcknowledgeN,
  output logic [hpsr_pkg::GP_W-1:0]         portBOut,
  output logic [hpsr_pkg::GP_W-1:0]         portBOe
);
  logic                        strobeDly_reg;
  logic [hpsr_pkg::GP_W-1:0]   gpDir_reg;
  logic [hpsr_pkg::GP_W-1:0]   gpOut_reg;
  logic [hpsr_pkg::DATA_W-1:0] rdData_reg;
  hpsr_pkg::hpsr_write_t       wr_reg;
  logic                        wrStb_reg;
  logic                        strobeActive;
  logic                        strobeRise;
  logic                        ackActive;
  logic [hpsr_pkg::GP_W-1:0]   pinIn;

  assign strobeActive = hostPortSel && !hostTransferStrobeN;
  // Deassertion edge; only meaningful in host-port mode
  assign strobeRise   = hostPortSel && !strobeDly_reg && hostTransferStrobeN;
  assign ackActive    = hostPortSel && !hostAcknowledgeN;
  assign pinIn        = {hostAcknowledgeN, hostServiceRequestIn, hostTransferStrobeN};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      strobeDly_reg <= 1'b1;
    end else if (clkEn) begin
      strobeDly_reg <= hostTransferStrobeN;
    end
  end

  // Write capture at strobe release
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_reg    <= '{sel: hpsr_pkg::SEL_RST, data: hpsr_pkg::DATA_RST};
      wrStb_reg <= 1'b0;
    end else if (clkEn) begin
      wrStb_reg <= strobeRise && !hostDirectionSelect; // RULE_03
      if (strobeRise && !hostDirectionSelect) begin
        wr_reg.data <= hostDataLinesIn; // RULE_03 RULE_02
        wr_reg.sel  <= hostRegisterSelect;
      end
    end
  end

  // Read data held in a flop so the bus does not glitch
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdData_reg <= hpsr_pkg::DATA_RST;
    end else if (clkEn) begin
      rdData_reg <= readData;
    end
  end

  // GPIO direction and level; reset leaves all three as inputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gpDir_reg <= hpsr_pkg::GP_RST; // RULE_08
      gpOut_reg <= hpsr_pkg::GP_RST;
    end else if (clkEn) begin
      gpDir_reg <= gpioCtl.dir;
      gpOut_reg <= gpioCtl.out;
    end
  end

  assign writeWord   = wr_reg;
  assign writeStrobe = wrStb_reg;
  // Also drive data when acknowledge arrives during a pending request
  assign hostDataLinesOe  = (strobeActive && hostDirectionSelect)
                          || (ackActive && servicePending); // RULE_01 RULE_02 RULE_12
  assign hostDataLinesOut = rdData_reg;
  assign hostServiceRequestOut = hostPortSel ? 1'b0 : gpOut_reg[hpsr_pkg::GP_REQ]; // RULE_14
  assign hostServiceRequestOe  = hostPortSel ? servicePending
                               : gpDir_reg[hpsr_pkg::GP_REQ]; // RULE_04 RULE_09
  assign dmaAck  = ackActive && servicePending; // RULE_05
  assign intAck  = ackActive && !servicePending; // RULE_06
  assign gpioIn  = hostPortSel ? hpsr_pkg::GP_RST : pinIn; // RULE_07
  assign portBOut = hostPortSel ? hpsr_pkg::GP_RST : gpOut_reg;
  assign portBOe  = hostPortSel ? hpsr_pkg::GP_RST
                  : (gpDir_reg & ~(3'h1 << hpsr_pkg::GP_REQ)); // RULE_07

  property p_ReadDrive;
    @(posedge sys_clk) disable iff (reset)
      (strobeActive && hostDirectionSelect && $past(clkEn && !reset))
        |-> (hostDataLinesOe && hostDataLinesOut == $past(readData));
  endproperty
  a_ReadDrive: assert property (p_ReadDrive) else $error("read not driven"); // RULE_01

  property p_WriteFloat;
    @(posedge sys_clk) disable iff (reset)
      (strobeActive && !hostDirectionSelect && !ackActive) |-> !hostDataLinesOe;
  endproperty
  a_WriteFloat: assert property (p_WriteFloat) else $error("write drove bus"); // RULE_02

  sequence s_WriteRelease;
    clkEn && strobeRise && !hostDirectionSelect;
  endsequence
  property p_Capture;
    @(posedge sys_clk) disable iff (reset)
      s_WriteRelease |=> (writeStrobe && writeWord.data == $past(hostDataLinesIn)
                          && writeWord.sel == $past(hostRegisterSelect));
  endproperty
  a_Capture: assert property (p_Capture) else $error("write not captured"); // RULE_03

  // Whole write seen at the pins: strobe low, then released with direction low
  sequence s_WriteHeld;
    clkEn && hostPortSel && !hostTransferStrobeN && !hostDirectionSelect;
  endsequence
  sequence s_WriteEnd;
    clkEn && hostPortSel && hostTransferStrobeN && !hostDirectionSelect;
  endsequence
  property p_WriteCycle;
    @(posedge sys_clk) disable iff (reset)
      s_WriteHeld ##1 s_WriteEnd |=> (writeStrobe
                                      && writeWord.data == $past(hostDataLinesIn)
                                      && writeWord.sel == $past(hostRegisterSelect));
  endproperty
  a_WriteCycle: assert property (p_WriteCycle) else $error("write cycle lost"); // RULE_03

  property p_StrobePulse;
    @(posedge sys_clk) disable iff (reset)
      (writeStrobe && clkEn) |=> !writeStrobe;
  endproperty
  a_StrobePulse: assert property (p_StrobePulse) else $error("strobe too long"); // RULE_03

  // A read release must not be taken as a write
  sequence s_ReadRelease;
    clkEn && strobeRise && hostDirectionSelect;
  endsequence
  property p_ReadNoCapture;
    @(posedge sys_clk) disable iff (reset)
      s_ReadRelease |=> !writeStrobe;
  endproperty
  a_ReadNoCapture: assert property (p_ReadNoCapture) else $error("read captured"); // RULE_01

  // Freeze holds the write word, write strobe and read data; a host write during a freeze is lost
  property p_Freeze;
    @(posedge sys_clk) disable iff (reset)
      !clkEn |=> ($stable(writeWord) && $stable(writeStrobe) && $stable(hostDataLinesOut));
  endproperty
  a_Freeze: assert property (p_Freeze) else $error("state moved while frozen");

  property p_ReqLow;
    @(posedge sys_clk) disable iff (reset)
      hostPortSel |-> (hostServiceRequestOe == servicePending && !hostServiceRequestOut);
  endproperty
  a_ReqLow: assert property (p_ReqLow) else $error("request level wrong"); // RULE_14

  property p_DmaAck;
    @(posedge sys_clk) disable iff (reset)
      (ackActive && servicePending) |-> (dmaAck && !intAck && hostDataLinesOe);
  endproperty
  a_DmaAck: assert property (p_DmaAck) else $error("dma ack wrong"); // RULE_05

  property p_IntAck;
    @(posedge sys_clk) disable iff (reset)
      (ackActive && !servicePending) |-> (intAck && !dmaAck);
  endproperty
  a_IntAck: assert property (p_IntAck) else $error("int ack wrong"); // RULE_06

  property p_AckIdle;
    @(posedge sys_clk) disable iff (reset)
      !ackActive |-> (!dmaAck && !intAck);
  endproperty
  a_AckIdle: assert property (p_AckIdle) else $error("ack without input"); // RULE_05

  property p_GpioMode;
    @(posedge sys_clk) disable iff (reset)
      !hostPortSel |-> (gpioIn == pinIn && !hostDataLinesOe);
  endproperty
  a_GpioMode: assert property (p_GpioMode) else $error("gpio fallback wrong"); // RULE_07

  property p_HostMode;
    @(posedge sys_clk) disable iff (reset)
      hostPortSel |-> (portBOe == hpsr_pkg::GP_RST && portBOut == hpsr_pkg::GP_RST
                       && gpioIn == hpsr_pkg::GP_RST);
  endproperty
  a_HostMode: assert property (p_HostMode) else $error("port B active in host mode"); // RULE_07

  // Lines 12 and 14 follow the control; line 13 leaves through the request pin
  property p_GpioDrive;
    @(posedge sys_clk) disable iff (reset)
      (!hostPortSel && $past(clkEn && !reset))
        |-> (portBOe[hpsr_pkg::GP_STROBE] == $past(gpioCtl.dir[hpsr_pkg::GP_STROBE])
             && portBOe[hpsr_pkg::GP_ACK] == $past(gpioCtl.dir[hpsr_pkg::GP_ACK])
             && portBOut[hpsr_pkg::GP_ACK] == $past(gpioCtl.out[hpsr_pkg::GP_ACK])
             && !portBOe[hpsr_pkg::GP_REQ]);
  endproperty
  a_GpioDrive: assert property (p_GpioDrive) else $error("port B drive wrong"); // RULE_07

  property p_GpioNoCapture;
    @(posedge sys_clk) disable iff (reset)
      (clkEn && !hostPortSel) |=> !writeStrobe;
  endproperty
  a_GpioNoCapture: assert property (p_GpioNoCapture) else $error("gpio write taken"); // RULE_07

  // First edge after release: direction registers still hold their reset value
  property p_ResetInputs;
    @(posedge sys_clk)
      ($past(reset) && !reset && !hostPortSel)
        |-> (portBOe == hpsr_pkg::GP_RST && !hostServiceRequestOe && !writeStrobe);
  endproperty
  a_ResetInputs: assert property (p_ResetInputs) else $error("not inputs after reset"); // RULE_08

  property p_PushPull;
    @(posedge sys_clk) disable iff (reset)
      (!hostPortSel && $past(clkEn && !reset))
        |-> (hostServiceRequestOe == $past(gpioCtl.dir[hpsr_pkg::GP_REQ])
             && hostServiceRequestOut == $past(gpioCtl.out[hpsr_pkg::GP_REQ]));
  endproperty
  a_PushPull: assert property (p_PushPull) else $error("line 13 not push-pull"); // RULE_09

  property p_Float;
    @(posedge sys_clk) disable iff (reset)
      (hostPortSel && hostTransferStrobeN && !ackActive) |-> !hostDataLinesOe;
  endproperty
  a_Float: assert property (p_Float) else $error("bus driven while idle"); // RULE_12
endmodule
`default_nettype wire

// ### hpsr_host_model.sv
// Host-side partner: one-cycle strobe, request pull-up and released data bus
`timescale 1ns/100ps
`default_nettype none
module hpsr_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Device drive
  input  wire logic [7:0] devData,
  input  wire logic       devDataOe,
  input  wire logic       reqOut,
  input  wire logic       reqOe,
  // Host pins and resolved levels
  output logic            strobeN,
  output logic            dirSel,
  output logic [2:0]      regSel,
  output logic [7:0]      busLevel,
  output logic            reqLevel,
  output logic            ackN
);
  logic [7:0] hostDrive;
  logic       hostOe;
  logic [7:0] lastLevel;
  initial begin
    strobeN = 1'b1;
    dirSel = 1'b0;
    regSel = 3'h0;
    hostDrive = 8'h00;
    hostOe = 1'b0;
    ackN = 1'b1;
  end
  // Floating bus shows the inverse, so a stale value never passes
  always_ff @(posedge sys_clk) lastLevel <= busLevel;
  assign busLevel = devDataOe ? devData : (hostOe ? hostDrive : ~lastLevel);
  assign reqLevel = reqOe ? reqOut : 1'b1;
  // Strobe is driven low across one clock edge; direction and select held throughout
  task automatic access(input logic rd, input logic [2:0] sel, input logic [7:0] d,
                        output logic [7:0] q, output logic oe);
    @(posedge sys_clk) #1;
    dirSel = rd;
    regSel = sel;
    hostDrive = d;
    hostOe = !rd;
    strobeN = 1'b0;
    @(posedge sys_clk);
    q = busLevel;
    oe = devDataOe;
    #1 strobeN = 1'b1;
    @(posedge sys_clk) #1;
    hostOe = 1'b0;
  endtask
  task automatic ack(input logic v);
    @(posedge sys_clk) #1;
    ackN = v;
  endtask
endmodule
`default_nettype wire

// ### hpsr_host_pins_tb.sv
// Self-checking bench for the host port pin block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin cmpCount++; if ((a) !== (e)) begin errTotal++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module hpsr_host_pins_tb;
  logic                  sys_clk = 1'b0, reset = 1'b1, hostPortSel = 1'b0, servicePending = 1'b0;
  logic                  strobeN, dirSel, reqLevel, ackN, oe, writeStrobe, dmaAck, intAck;
  logic                  dataOe, reqOut, reqOe, clkEn = 1'b1;
  logic [7:0]            readData = 8'h00, q, busLevel, dataOut;
  logic [2:0]            regSel, gpioIn, portBOut, portBOe;
  hpsr_pkg::hpsr_gpio_t  gpioCtl = 6'h38;
  hpsr_pkg::hpsr_write_t writeWord, e;
  hpsr_pkg::hpsr_write_t expq[$];
  int                    seed = 32'h34a9, errTotal = 0, cmpCount = 0, cyc = 0, r;
  hpsr_host_pins hpsr_host_pins_inst (.sys_clk, .reset, .clkEn, .hostPortSel, .readData,
    .servicePending, .gpioCtl, .writeWord, .writeStrobe, .dmaAck, .intAck, .gpioIn,
    .hostTransferStrobeN(strobeN), .hostDirectionSelect(dirSel), .hostRegisterSelect(regSel),
    .hostDataLinesIn(busLevel), .hostDataLinesOut(dataOut), .hostDataLinesOe(dataOe),
    .hostServiceRequestIn(reqLevel), .hostServiceRequestOut(reqOut),
    .hostServiceRequestOe(reqOe), .hostAcknowledgeN(ackN), .portBOut, .portBOe);
  hpsr_host_model hpsr_host_model_inst (.sys_clk, .devData(dataOut), .devDataOe(dataOe),
    .reqOut, .reqOe, .strobeN, .dirSel, .regSel, .busLevel, .reqLevel, .ackN);
  initial forever #4 sys_clk = ~sys_clk;
  task automatic testDone();
    $display("checks %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 500) begin
      errTotal++;
      testDone();
    end
  end
  // Every strobe pulse must match the oldest noted write
  always @(negedge sys_clk) begin
    if (writeStrobe !== 1'b0 && !reset) begin
      e = (expq.size() > 0) ? expq.pop_front() : 11'h7ff;
      `CHK("writeWord", e, writeWord)
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 `CHK("resetOe", 4'h0, {portBOe, reqOe})
    reset = 1'b0;
    hostPortSel = 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      expq.push_back(r[10:0]);
      hpsr_host_model_inst.access(1'b0, r[10:8], r[7:0], q, oe);
      `CHK("writeOe", 1'b0, oe)
    end
    $display("test writes done");
    r = $random(seed);
    readData = r[7:0];
    hpsr_host_model_inst.access(1'b1, 3'h2, 8'h00, q, oe);
    `CHK("readData", readData, q)
    `CHK("readOe", 1'b1, oe)
    `CHK("idleOe", 1'b0, dataOe)
    $display("test read done");
    servicePending = 1'b1;
    hpsr_host_model_inst.ack(1'b0);
    #1 `CHK("dmaAck", 5'h15, {reqOe, reqLevel, dmaAck, intAck, dataOe})
    @(posedge sys_clk) #1 servicePending = 1'b0;
    #1 `CHK("intAck", 5'h0a, {reqOe, reqLevel, dmaAck, intAck, dataOe})
    `CHK("hostMode", 9'h0, {gpioIn, portBOut, portBOe})
    hpsr_host_model_inst.ack(1'b1);
    $display("test request done");
    // Host write during a freeze is lost; the edge detector is held as well
    clkEn = 1'b0;
    hpsr_host_model_inst.access(1'b0, 3'h3, 8'ha5, q, oe);
    clkEn = 1'b1;
    @(posedge sys_clk) #1 `CHK("frozen", e, writeWord)
    $display("test freeze done");
    hostPortSel = 1'b0;
    r = $random(seed);
    gpioCtl = {3'h7, r[2:0]};
    reset = 1'b1;
    @(posedge sys_clk) #1 reset = 1'b0;
    `CHK("midReset", 15'h0, {portBOe, reqOe, writeWord})
    repeat (2) @(posedge sys_clk);
    #1 `CHK("gpio", {r[2:0], 3'h5, 1'b1, r[1], 1'b1, r[1], 1'b1},
      {portBOut, portBOe, reqOe, reqOut, gpioIn})
    hpsr_host_model_inst.access(1'b0, 3'h1, 8'h5a, q, oe);
    repeat (3) @(posedge sys_clk);
    `CHK("pending", 0, expq.size())
    $display("test gpio done");
    testDone();
  end
endmodule
`default_nettype wire
